// ===== inc/autoflow_pkg.sv
// Shared constants and carrier types for the serial flow-control block.
package autoflow_pkg;

  // ---------------------------------------------------------------
  // Sizes and timing
  // ---------------------------------------------------------------
  localparam int          QUEUE_DEPTH_DEFAULT = 16;
  localparam int          DATA_BITS           = 8;
  localparam int          BIT_CYCLES_DEFAULT  = 16;
  localparam int          SYNC_STAGES         = 2;
  localparam logic [4:0]  LEVEL_RESET         = 5'h00;
  localparam logic        LINE_IDLE           = 1'b1;
  localparam logic        RTS_N_RESET         = 1'b1;

  // ---------------------------------------------------------------
  // Receive trigger level selection
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TRIG_1  = 2'h0,
    TRIG_4  = 2'h1,
    TRIG_8  = 2'h2,
    TRIG_14 = 2'h3
  } trig_sel_e;

  localparam logic [4:0]  TRIG_BYTES_1  = 5'h01;
  localparam logic [4:0]  TRIG_BYTES_4  = 5'h04;
  localparam logic [4:0]  TRIG_BYTES_8  = 5'h08;
  localparam logic [4:0]  TRIG_BYTES_14 = 5'h0E;
  localparam logic [4:0]  LEVEL_BEFORE_16TH = 5'h0F;

  // ---------------------------------------------------------------
  // Transmitter states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    TX_IDLE  = 4'h1,
    TX_START = 4'h2,
    TX_DATA  = 4'h4,
    TX_STOP  = 4'h8
  } tx_state_e;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [4:0] level;
    logic       empty;
    logic       full;
    logic       overrun;
  } rx_status_s;

  typedef struct packed {
    logic       auto_rts;
    logic       auto_cts;
    logic       manual_rts;
  } flow_mode_s;

endpackage

// ===== rtl/two_entry_buffer.sv
// Two-entry valid/ready buffer that absorbs one stall without losing a word.
module two_entry_buffer
  import autoflow_pkg::*;
#(
  parameter int WIDTH = DATA_BITS
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  // ---------------------------------------------------------------
  // Storage: head word and overflow word
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] head_reg, head_next;
  logic [WIDTH-1:0] spare_reg, spare_next;
  logic [1:0]       cnt_reg, cnt_next;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = head_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    head_next  = head_reg;
    spare_next = spare_reg;
    cnt_next   = cnt_reg;
    unique case ({push, pop})
      2'b10: begin
        if (cnt_reg == 2'h0) begin
          head_next = in_data;
        end else begin
          spare_next = in_data;
        end
        cnt_next = cnt_reg + 2'h1;
      end
      2'b01: begin
        head_next = spare_reg;
        cnt_next  = cnt_reg - 2'h1;
      end
      2'b11: begin
        if (cnt_reg == 2'h1) begin
          head_next = in_data;
        end else begin
          head_next  = spare_reg;
          spare_next = in_data;
        end
      end
      2'b00: begin
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      head_reg  <= '0;
      spare_reg <= '0;
      cnt_reg   <= 2'h0;
    end else begin
      head_reg  <= head_next;
      spare_reg <= spare_next;
      cnt_reg   <= cnt_next;
    end
  end

endmodule

// ===== rtl/uart_autoflow_control.sv
// Automatic RTS/CTS flow control for one serial channel with receive queue and transmitter.
// Operation
// - Under auto-CTS no transmit byte starts unless CTS is active; a byte in flight finishes.
// - Triggers 1, 4, 8: RTS goes inactive when fill reaches the trigger.
// - Triggers 1, 4, 8: one more byte after RTS drops is still accepted.
// - Triggers 1, 4, 8: RTS returns only when reads empty the queue.
// - Trigger 14: RTS drops at first data bit of the sixteenth character.
// - Trigger 14: RTS returns once the queue has room for a byte.
// - Under auto-CTS, CTS is checked before each byte; active means start.
// - With flow control on, CTS changes raise no host interrupt event.
// - Full autoflow needs autoflow enable and the RTS control bit both set.
// - Without auto-CTS the transmitter sends regardless of CTS.
// - RTS output is active low, driven low by RTS bit, high after reset.
module uart_autoflow_control
  import autoflow_pkg::*;
#(
  parameter int QUEUE_DEPTH = QUEUE_DEPTH_DEFAULT,
  parameter int BIT_CYCLES  = BIT_CYCLES_DEFAULT
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 autoflow_enable_bit,
  input  wire logic                 rts_bit,
  input  wire trig_sel_e            trig_sel,
  input  wire logic                 cts_n,
  output logic                      rts_n,
  output logic                      cts_delta_event,
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  input  wire logic [DATA_BITS-1:0] tx_data,
  output logic                      tx_line,
  input  wire logic                 rx_first_bit,
  input  wire logic                 rx_valid,
  input  wire logic [DATA_BITS-1:0] rx_data,
  input  wire logic                 host_read,
  output logic [DATA_BITS-1:0]      read_data,
  output logic                      read_valid,
  output rx_status_s                rx_status
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic [SYNC_STAGES-1:0] rst_sync_reg;
  logic                   rst_int_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= '0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[SYNC_STAGES-2:0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_reg[SYNC_STAGES-1];

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  function automatic logic [4:0] trig_bytes(input trig_sel_e sel);
    unique case (sel)
      TRIG_1:  trig_bytes = TRIG_BYTES_1;
      TRIG_4:  trig_bytes = TRIG_BYTES_4;
      TRIG_8:  trig_bytes = TRIG_BYTES_8;
      TRIG_14: trig_bytes = TRIG_BYTES_14;
    endcase
  endfunction

  flow_mode_s mode;
  assign mode.auto_rts   = autoflow_enable_bit && rts_bit;
  assign mode.auto_cts   = autoflow_enable_bit;
  assign mode.manual_rts = rts_bit;

  // ---------------------------------------------------------------
  // Receive queue
  // ---------------------------------------------------------------
  localparam logic [4:0] DEPTH5 = 5'(QUEUE_DEPTH);
  logic [DATA_BITS-1:0] mem_reg [QUEUE_DEPTH];
  logic [3:0]           wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [4:0]           level_reg, level_next;
  logic [DATA_BITS-1:0] rdata_reg, rdata_next;
  logic                 rvalid_reg, rvalid_next, ovr_reg, ovr_next;
  logic                 full, empty, push, pop;

  assign full  = (level_reg == DEPTH5);
  assign empty = (level_reg == LEVEL_RESET);
  assign pop   = host_read && !empty;
  // Bytes are taken whatever RTS shows; only a truly full queue drops one.
  assign push  = rx_valid && (!full || pop);

  always_comb begin
    wptr_next   = wptr_reg;
    rptr_next   = rptr_reg;
    level_next  = level_reg;
    rdata_next  = rdata_reg;
    rvalid_next = pop;
    ovr_next    = rx_valid && !push;
    if (push) begin
      wptr_next = wptr_reg + 4'h1;
    end
    if (pop) begin
      rptr_next  = rptr_reg + 4'h1;
      rdata_next = mem_reg[rptr_reg];
    end
    if (push && !pop) begin
      level_next = level_reg + 5'h01;
    end else if (pop && !push) begin
      level_next = level_reg - 5'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wptr_reg] <= rx_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      wptr_reg   <= 4'h0;
      rptr_reg   <= 4'h0;
      level_reg  <= LEVEL_RESET;
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
      ovr_reg    <= 1'b0;
    end else begin
      wptr_reg   <= wptr_next;
      rptr_reg   <= rptr_next;
      level_reg  <= level_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      ovr_reg    <= ovr_next;
    end
  end

  assign read_data         = rdata_reg;
  assign read_valid        = rvalid_reg;
  assign rx_status.level   = level_reg;
  assign rx_status.empty   = empty;
  assign rx_status.full    = full;
  assign rx_status.overrun = ovr_reg;

  // ---------------------------------------------------------------
  // Auto-RTS
  // ---------------------------------------------------------------
  logic hold_reg, hold_next, rts_n_reg, rts_n_next;

  always_comb begin
    hold_next = hold_reg;
    if (trig_sel == TRIG_14) begin
      // Set wins over clear so a start bit racing a read is not lost.
      if (rx_first_bit && level_reg >= LEVEL_BEFORE_16TH) begin
        hold_next = 1'b1;
      end else if (pop || level_next < LEVEL_BEFORE_16TH) begin
        hold_next = 1'b0;
      end
    end else begin
      if (level_next >= trig_bytes(trig_sel)) begin
        hold_next = 1'b1;
      end else if (level_next == LEVEL_RESET) begin
        hold_next = 1'b0;
      end
    end
    if (!mode.manual_rts) begin
      rts_n_next = 1'b1;
    end else if (mode.auto_rts) begin
      rts_n_next = hold_next;
    end else begin
      rts_n_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      hold_reg  <= 1'b0;
      rts_n_reg <= RTS_N_RESET;
    end else begin
      hold_reg  <= hold_next;
      rts_n_reg <= rts_n_next;
    end
  end
  assign rts_n = rts_n_reg;

  // ---------------------------------------------------------------
  // CTS change event for the modem status path
  // ---------------------------------------------------------------
  logic cts_prev_reg, delta_reg, delta_next;

  always_comb begin
    delta_next = (cts_n != cts_prev_reg) && !mode.auto_cts;
  end

  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      cts_prev_reg <= 1'b1;
      delta_reg    <= 1'b0;
    end else begin
      cts_prev_reg <= cts_n;
      delta_reg    <= delta_next;
    end
  end
  assign cts_delta_event = delta_reg;

  // ---------------------------------------------------------------
  // Transmit buffer and serializer
  // ---------------------------------------------------------------
  logic                 buf_valid, buf_ready, cts_ok;
  logic [DATA_BITS-1:0] buf_data;

  two_entry_buffer #(.WIDTH(DATA_BITS)) u_buf (
    .clk       (sys_clk),
    .rst_n     (rst_int_n),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_data)
  );

  localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
  tx_state_e            st_reg, st_next;
  logic [15:0]          cnt_reg, cnt_next;
  logic [2:0]           bitn_reg, bitn_next;
  logic [DATA_BITS-1:0] sh_reg, sh_next;
  logic                 line_reg, line_next, bit_end;

  // CTS is looked at only in idle, i.e. after the stop bit, so a release
  // before mid stop bit always stops the next byte.
  assign cts_ok    = !mode.auto_cts || !cts_n;
  assign buf_ready = (st_reg == TX_IDLE) && cts_ok;
  assign bit_end   = (cnt_reg == BIT_LAST);

  always_comb begin
    st_next   = st_reg;
    cnt_next  = bit_end ? 16'h0000 : cnt_reg + 16'h0001;
    bitn_next = bitn_reg;
    sh_next   = sh_reg;
    line_next = line_reg;
    unique case (st_reg)
      TX_IDLE: begin
        cnt_next  = 16'h0000;
        line_next = LINE_IDLE;
        if (buf_valid && buf_ready) begin
          st_next   = TX_START;
          sh_next   = buf_data;
          line_next = 1'b0;
        end
      end
      TX_START: begin
        if (bit_end) begin
          st_next   = TX_DATA;
          bitn_next = 3'h0;
          line_next = sh_reg[0];
        end
      end
      TX_DATA: begin
        if (bit_end) begin
          sh_next   = sh_reg >> 1;
          bitn_next = bitn_reg + 3'h1;
          if (bitn_reg == 3'h7) begin
            st_next   = TX_STOP;
            line_next = LINE_IDLE;
          end else begin
            line_next = sh_reg[1];
          end
        end
      end
      TX_STOP: begin
        if (bit_end) begin
          st_next = TX_IDLE;
        end
      end
      default: begin
        st_next   = TX_IDLE;
        line_next = LINE_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      st_reg   <= TX_IDLE;
      cnt_reg  <= 16'h0000;
      bitn_reg <= 3'h0;
      sh_reg   <= '0;
      line_reg <= LINE_IDLE;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      bitn_reg <= bitn_next;
      sh_reg   <= sh_next;
      line_reg <= line_next;
    end
  end
  assign tx_line = line_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_int_n);

  sequence s_held;
    st_reg == TX_IDLE && mode.auto_cts && cts_n;
  endsequence
  sequence s_take;
    st_reg == TX_IDLE && buf_valid && buf_ready;
  endsequence

  a_cts_blocks: assert property (s_held |=> st_reg == TX_IDLE && tx_line)
    else $error("byte started while CTS inactive");
  a_cts_starts: assert property (s_take |=> st_reg == TX_START ##1 !tx_line)
    else $error("byte not started when CTS active");
  a_free_send: assert property (!mode.auto_cts && st_reg == TX_IDLE && buf_valid |=> st_reg == TX_START)
    else $error("transmitter waited without auto-CTS");
  a_hold_idle: assert property ((s_held and buf_valid) |=> buf_valid && tx_line)
    else $error("held byte lost or line not idle");
  a_trig_drop: assert property (mode.auto_rts && trig_sel != TRIG_14
      && level_reg >= trig_bytes(trig_sel) |-> rts_n)
    else $error("RTS active at trigger level");
  a_extra_byte: assert property (rx_valid && !full && !pop |=> level_reg == $past(level_reg) + 5'h01)
    else $error("byte after RTS drop not stored");
  a_empty_return: assert property (mode.auto_rts && $past(mode.auto_rts) && trig_sel != TRIG_14
      && empty |-> !rts_n)
    else $error("RTS not back with empty queue");
  a_sixteenth: assert property (mode.auto_rts && trig_sel == TRIG_14 && rx_first_bit
      && level_reg >= LEVEL_BEFORE_16TH |=> rts_n)
    else $error("RTS not dropped for sixteenth character");
  a_room_return: assert property (mode.auto_rts && trig_sel == TRIG_14 && pop && !rx_first_bit
      |=> !rts_n)
    else $error("RTS not back with room in queue");
  a_no_cts_event: assert property (mode.auto_cts |=> !cts_delta_event)
    else $error("CTS change raised event under flow control");
  a_rts_manual: assert property (!rts_bit |=> rts_n)
    else $error("RTS low with control bit clear");

endmodule

// ===== sim/remote_serial_model.sv
// Behavioural remote serial device that faces the flow-control block.
module remote_serial_model
  import autoflow_pkg::*;
#(
  parameter int BIT_CYCLES = 4
) (
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  input  wire logic            tx_line,
  input  wire logic            rts_n,
  input  wire logic            cts_hold,
  output logic                 cts_n,
  output logic                 rx_first_bit,
  output logic                 rx_valid,
  output logic [DATA_BITS-1:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [DATA_BITS-1:0] got_q[$];
  logic [DATA_BITS-1:0] shift;

  initial begin
    cts_n        = 1'b1;
    rx_first_bit = 1'b0;
    rx_valid     = 1'b0;
    rx_data      = 8'hFF;
  end

  // A stop reaches cts_n one clock after cts_hold, so one asked early in a frame lands before mid stop bit.
  always @(posedge sys_clk) cts_n <= cts_hold;

  // A polite sender waits for RTS; the bench may skip that for a byte already in flight.
  task automatic send_byte(input logic [DATA_BITS-1:0] b, input bit heed);
    int n = 0;
    while (heed && rts_n !== 1'b0 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    rx_first_bit <= 1'b1;
    @(posedge sys_clk);
    rx_first_bit <= 1'b0;
    repeat (8 * BIT_CYCLES) @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_data  <= b;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_data  <= ~b;
  endtask

  // Samples each bit near its middle, LSB first; only well-framed bytes are kept.
  initial begin
    forever begin
      @(posedge sys_clk);
      if (rst_n === 1'b1 && tx_line === 1'b0) begin
        repeat (BIT_CYCLES / 2) @(posedge sys_clk);
        for (int i = 0; i < DATA_BITS; i++) begin
          repeat (BIT_CYCLES) @(posedge sys_clk);
          shift[i] = tx_line;
        end
        repeat (BIT_CYCLES) @(posedge sys_clk);
        if (tx_line === LINE_IDLE) got_q.push_back(shift);
      end
    end
  end
endmodule

// ===== sim/uart_autoflow_control_tb.sv
// Self-checking bench for the serial flow-control block.
module uart_autoflow_control_tb
  import autoflow_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BITS  = 4;
  localparam int LIMIT = 20000;

  logic       sys_clk, rst_n, autoflow_enable_bit, rts_bit, cts_n, rts_n, cts_delta_event, cts_hold;
  logic       tx_valid, tx_ready, tx_line, rx_first_bit, rx_valid, host_read, read_valid;
  logic [7:0] tx_data, rx_data, read_data;
  trig_sel_e  trig_sel;
  rx_status_s rx_status;
  int         num_errors = 0, checks = 0, cycles = 0, low_cnt = 0, delta_cnt = 0;

  uart_autoflow_control #(.BIT_CYCLES(BITS)) dut (
    .sys_clk, .rst_n, .autoflow_enable_bit, .rts_bit, .trig_sel, .cts_n, .rts_n, .cts_delta_event,
    .tx_valid, .tx_ready, .tx_data, .tx_line, .rx_first_bit, .rx_valid, .rx_data, .host_read,
    .read_data, .read_valid, .rx_status
  );
  remote_serial_model #(.BIT_CYCLES(BITS)) remote (
    .sys_clk, .rst_n, .tx_line, .rts_n, .cts_hold, .cts_n, .rx_first_bit, .rx_valid, .rx_data
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (tx_line === 1'b0) low_cnt++;
    if (cts_delta_event === 1'b1) delta_cnt++;
    if (cycles == LIMIT) begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize();
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Extra settling covers the one-clock cts_n register in the remote model before any judgement.
  task automatic set_mode(input logic afe, input logic rts, input trig_sel_e sel, input logic cts);
    @(posedge sys_clk);
    autoflow_enable_bit <= afe;
    rts_bit             <= rts;
    trig_sel            <= sel;
    cts_hold            <= cts;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  task automatic tx_push(input logic [7:0] b);
    int k = 0;
    @(posedge sys_clk);
    tx_valid <= 1'b1;
    tx_data  <= b;
    do begin
      @(posedge sys_clk);
      k++;
    end while (tx_ready !== 1'b1 && k < 400);
    tx_valid <= 1'b0;
  endtask

  task automatic read_one(input logic [7:0] exp);
    @(posedge sys_clk);
    host_read <= 1'b1;
    @(posedge sys_clk);
    host_read <= 1'b0;
    #1;
    check({read_valid, read_data}, {1'b1, exp});
  endtask

  task automatic wait_got(input int n);
    int k = 0;
    while (remote.got_q.size() < n && k < 400) begin
      @(posedge sys_clk);
      k++;
    end
    #1;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_manual();
    check(rts_n, 1'b1);
    check(tx_line, LINE_IDLE);
    set_mode(1'b0, 1'b1, TRIG_1, 1'b0);
    check(rts_n, 1'b0);
    set_mode(1'b0, 1'b0, TRIG_1, 1'b0);
    check(rts_n, 1'b1);
  endtask

  task automatic t_trig(input trig_sel_e sel, input int n);
    set_mode(1'b1, 1'b1, sel, 1'b0);
    check(rts_n, 1'b0);
    for (int i = 0; i < n; i++) begin
      remote.send_byte(8'(i), 1'b1);
      #1;
      check(rts_n, i == n - 1);
    end
    remote.send_byte(8'(n), 1'b0);
    #1;
    check(rx_status.level, 5'(n + 1));
    for (int i = 0; i <= n; i++) begin
      read_one(8'(i));
      check(rts_n, i != n);
    end
    check(rx_status.empty, 1'b1);
  endtask

  task automatic t_trig14();
    set_mode(1'b1, 1'b1, TRIG_14, 1'b0);
    for (int i = 0; i < 15; i++) begin
      remote.send_byte(8'(i), 1'b1);
      #1;
      check(rts_n, 1'b0);
    end
    fork
      remote.send_byte(8'h0F, 1'b1);
      begin
        repeat (2) @(posedge sys_clk);
        #1;
        check(rts_n, 1'b1);
      end
    join
    #1;
    check(rx_status.level, 5'h10);
    check({rx_status.full, rx_status.empty}, 2'b10);
    remote.send_byte(8'h10, 1'b0);
    #1;
    check({rx_status.level, rx_status.overrun}, {5'h10, 1'b1});
    read_one(8'h00);
    @(posedge sys_clk);
    #1;
    check(rts_n, 1'b0);
    for (int i = 1; i < 16; i++) read_one(8'(i));
  endtask

  task automatic t_cts_hold();
    int base, dbase, lbase;
    set_mode(1'b1, 1'b0, TRIG_1, 1'b1);
    check(rts_n, 1'b1);
    base  = remote.got_q.size();
    dbase = delta_cnt;
    lbase = low_cnt;
    tx_push(8'hA5);
    tx_push(8'h3C);
    #1;
    check(tx_ready, 1'b0);
    repeat (60) @(posedge sys_clk);
    #1;
    check(low_cnt - lbase, 0);
    @(posedge sys_clk);
    cts_hold <= 1'b0;
    wait_got(base + 2);
    check(remote.got_q[base], 8'hA5);
    check(remote.got_q[base + 1], 8'h3C);
    check(delta_cnt - dbase, 0);
  endtask

  task automatic t_mid_stop();
    int base, lbase, k;
    set_mode(1'b1, 1'b0, TRIG_1, 1'b0);
    base  = remote.got_q.size();
    lbase = low_cnt;
    k     = 0;
    tx_push(8'h81);
    tx_push(8'h7E);
    while (low_cnt == lbase && k < 50) begin
      @(posedge sys_clk);
      k++;
    end
    cts_hold <= 1'b1;
    repeat (120) @(posedge sys_clk);
    #1;
    check(remote.got_q.size() - base, 1);
    check(remote.got_q[base], 8'h81);
    @(posedge sys_clk);
    cts_hold <= 1'b0;
    wait_got(base + 2);
    check(remote.got_q[base + 1], 8'h7E);
  endtask

  task automatic t_no_auto();
    int base, dbase;
    set_mode(1'b0, 1'b0, TRIG_1, 1'b1);
    base  = remote.got_q.size();
    dbase = delta_cnt;
    tx_push(8'h55);
    tx_push(8'hC3);
    wait_got(base + 2);
    check(remote.got_q[base], 8'h55);
    check(remote.got_q[base + 1], 8'hC3);
    @(posedge sys_clk);
    cts_hold <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    check(delta_cnt - dbase, 1);
  endtask

  initial begin
    rst_n               = 1'b0;
    autoflow_enable_bit = 1'b0;
    rts_bit             = 1'b0;
    trig_sel            = TRIG_1;
    tx_valid            = 1'b0;
    tx_data             = 8'h00;
    host_read           = 1'b0;
    cts_hold            = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    t_manual();
    t_trig(TRIG_1, 1);
    t_trig(TRIG_4, 4);
    t_trig(TRIG_8, 8);
    t_trig14();
    t_cts_hold();
    t_mid_stop();
    t_no_auto();
    summarize();
  end
endmodule
